// >>> common/spc_pkg.sv
// shared constants and helpers for the sector-protection command link
package spc_pkg;

   // ---------------------------------------------------------------
   // opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
   localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
   localparam logic [7:0] OP_LOCK_CLEAR = 8'hA6;
   localparam logic [7:0] OP_LOCK_READ = 8'hA7;
   localparam logic [7:0] OP_PROTECT_ERASE = 8'hE4;
   localparam logic [7:0] OP_PW_READ = 8'hE7;
   localparam logic [7:0] OP_PW_PROGRAM = 8'hE8;
   localparam logic [7:0] OP_PW_UNLOCK = 8'hE9;
   localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
   localparam logic [7:0] OP_MODE_RELEASE = 8'hFF;

   // ---------------------------------------------------------------
   // frame sizes, status layout, reset values
   // ---------------------------------------------------------------
   localparam logic [6:0] OPC_BITS = 7'h08;
   localparam logic [6:0] FRAME_BITS = 7'h48; // opcode plus password
   localparam logic [6:0] CNT_MAX = 7'h7F;
   localparam logic [6:0] PW_RX_BITS = 7'h40;
   localparam int SR_WIP = 0;
   localparam int SR_WEL = 1;
   localparam int SR_P_ERR = 6;
   localparam logic [7:0] PPB_ERASED = 8'hFF;
   localparam logic [63:0] PW_ERASED = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [2:0] BP_RESET = 3'h0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int REF_CLK_MHZ = 50;
   localparam int OP_TIME_NS = 50000; // self-timed operation length
   localparam logic [11:0] OP_CYCLES =
      12'((OP_TIME_NS * REF_CLK_MHZ + 999) / 1000);
   localparam int RECOVERY_TIME_NS = 35000; // reset_recovery_time
   localparam logic [11:0] RECOVERY_CYCLES =
      12'((RECOVERY_TIME_NS * REF_CLK_MHZ + 999) / 1000);
   localparam int LINK_MAX_MHZ = 133;
   localparam logic [2:0] SCK_HALF = 3'h4; // ref cycles per half period
   localparam int SCK_MHZ = REF_CLK_MHZ / (2 * 4);
   localparam logic [4:0] CS_GAP_CYCLES = 5'h10;

   // byte k of the stream becomes byte k of the value
   function automatic logic [63:0] byte_swap64(input logic [63:0] v);
      logic [63:0] r;
      r = '0;
      for (int k = 0; k < 8; k++) begin
         r[8*k +: 8] = v[8*(7-k) +: 8];
      end
      return r;
   endfunction

   // value bit carried by stream bit s: low byte first, msb first
   function automatic logic [5:0] stream_pos(input logic [5:0] s);
      return {s[5:3], 3'h7 - s[2:0]};
   endfunction

endpackage

// >>> common/spc_if.sv
// serial link between the flash command end and its host
`timescale 1ns/10ps
`default_nettype none
interface spc_if;
   logic sck;
   logic cs_n;
   logic si;
   logic so;
   modport dev(input sck, input cs_n, input si, output so);
   modport host(output sck, output cs_n, output si, input so);
endinterface
`default_nettype wire

// >>> hw/spc_flash.sv
// flash end: protection, password and reset command interpreter
`timescale 1ns/10ps
`default_nettype none
module spc_flash
   import spc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   spc_if.dev link,
   input wire logic pw_mode_sel_n,
   input wire logic cfg_load,
   input wire logic cfg_freeze,
   input wire logic cfg_block_protect_volatility,
   input wire logic [2:0] cfg_bp,
   input wire logic cont_mode_enter,
   output logic write_enable_latch,
   output logic write_in_progress,
   output logic program_error,
   output logic protect_lock,
   output logic [7:0] persistent_protect_bits,
   output logic [2:0] block_protect,
   output logic config_freeze,
   output logic cont_read_mode
);

   typedef enum logic [2:0] {
      S_INIT, S_IDLE, S_BUSY, S_FAIL, S_RECOVER
   } spc_dev_state_e;
   typedef enum logic [1:0] {
      K_ERASE, K_CLEAR, K_PROG, K_UNLOCK
   } spc_op_kind_e;

   // ---------------------------------------------------------------
   // link clock domain: shifter and read-out
   // ---------------------------------------------------------------
   logic frame_rst;
   logic fresh;
   logic [6:0] bit_cnt;
   logic [71:0] shift;
   logic [5:0] rd_idx;
   logic [7:0] rd_op;
   logic [73:0] mir_a;
   logic [73:0] mir_b;
   logic [73:0] mir_src;
   logic pwm_b;
   logic lock_b;
   logic [7:0] st_b;
   logic [63:0] pw_b;

   assign frame_rst = link.cs_n | ~rstn;

   // marks the first clock of a frame; raised while select is high
   always_ff @(posedge link.sck or posedge frame_rst) begin
      if (frame_rst) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   // shift in on rising edges, count bits and capture the opcode
   always_ff @(posedge link.sck or negedge rstn) begin
      if (!rstn) begin
         bit_cnt <= '0;
         shift <= '0;
         rd_idx <= '0;
         rd_op <= '0;
      end else if (fresh) begin
         bit_cnt <= 7'h01;
         shift <= {71'h0, link.si};
         rd_idx <= '0;
         rd_op <= '0;
      end else begin
         if (bit_cnt != CNT_MAX) begin
            bit_cnt <= bit_cnt + 7'h01;
         end
         shift <= {shift[70:0], link.si};
         if (bit_cnt >= OPC_BITS) begin
            rd_idx <= rd_idx + 6'h01;
         end
         if (bit_cnt == OPC_BITS - 7'h01) begin
            rd_op <= {shift[6:0], link.si};
         end
      end
   end

   // two-stage mirror of core state; updates on every link clock rising edge
   always_ff @(posedge link.sck or negedge rstn) begin
      if (!rstn) begin
         mir_a <= '0;
         mir_b <= '0;
      end else begin
         mir_a <= mir_src;
         mir_b <= mir_a;
      end
   end
   assign {pwm_b, lock_b, st_b, pw_b} = mir_b;

   // read data out on falling edges
   always_ff @(negedge link.sck or negedge rstn) begin
      if (!rstn) begin
         link.so <= 1'b0;
      end else if (bit_cnt < OPC_BITS) begin
         link.so <= 1'b0;
      end else begin
         case (rd_op)
            OP_READ_STATUS: link.so <= st_b[3'h7 - rd_idx[2:0]];
            OP_LOCK_READ: link.so <= (rd_idx[2:0] == 3'h7) & lock_b;
            OP_PW_READ: link.so <= pwm_b & pw_b[stream_pos(rd_idx)];
            default: link.so <= 1'b0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // core domain: frame end detection and decode
   // ---------------------------------------------------------------
   logic [2:0] cs_s;
   logic cs_lvl;
   logic frame_done;
   logic cmd8;
   logic cmd72;
   spc_dev_state_e state;
   spc_dev_state_e next_state;
   spc_op_kind_e kind;
   logic [11:0] timer;
   logic [63:0] pending;
   logic [63:0] password;
   logic pw_mode_q;
   logic [7:0] st_q;
   logic idle;
   logic start_erase, start_clear, start_prog, start_unlock;
   logic do_write_enable_cmd, do_clear_status_cmd, do_sreset, do_mbr;
   logic busy_done, mismatch, prog_bad, op_fails;

   // select passes three flops; a change counts when two agree
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cs_s <= 3'h7;
         cs_lvl <= 1'b1;
      end else begin
         cs_s <= {cs_s[1:0], link.cs_n};
         if (cs_s[1] == cs_s[2]) begin
            cs_lvl <= cs_s[2];
         end
      end
   end

   // frame info is still while select is high and the clock stands
   assign frame_done = cs_s[1] & cs_s[2] & ~cs_lvl;
   assign cmd8 = frame_done & (bit_cnt == OPC_BITS);
   assign cmd72 = frame_done & (bit_cnt == FRAME_BITS);
   assign idle = (state == S_IDLE);
   assign start_erase = idle & cmd8 & (rd_op == OP_PROTECT_ERASE)
      & write_enable_latch;
   assign start_clear = idle & cmd8 & (rd_op == OP_LOCK_CLEAR)
      & write_enable_latch;
   assign start_prog = idle & cmd72 & (rd_op == OP_PW_PROGRAM)
      & write_enable_latch & pw_mode_q;
   assign start_unlock = idle & cmd72 & (rd_op == OP_PW_UNLOCK);
   assign do_write_enable_cmd = idle & cmd8 & (rd_op == OP_WRITE_ENABLE);
   assign do_clear_status_cmd = cmd8 & (rd_op == OP_CLEAR_STATUS)
      & (idle | state == S_FAIL);
   assign do_sreset = cmd8 & (rd_op == OP_SOFT_RESET)
      & (state != S_RECOVER) & (state != S_INIT);
   assign do_mbr = idle & cmd8 & (rd_op == OP_MODE_RELEASE);
   assign mismatch = (pending != password);
   assign prog_bad = |(pending & ~password);
   assign op_fails = (kind == K_UNLOCK & mismatch)
      | (kind == K_PROG & prog_bad);
   assign busy_done = (state == S_BUSY) & (timer == 12'h000) & ~do_sreset;

   // next state; an erase suspend opcode is never decoded, so a
   // running protection erase cannot be suspended
   always_comb begin
      next_state = state;
      unique case (state)
         S_INIT: next_state = S_IDLE;
         S_IDLE: begin
            if (do_sreset) begin
               next_state = S_RECOVER;
            end else if (start_erase | start_clear | start_prog
                         | start_unlock) begin
               next_state = S_BUSY;
            end
         end
         S_BUSY: begin
            if (do_sreset) begin
               next_state = S_RECOVER;
            end else if (busy_done) begin
               next_state = op_fails ? S_FAIL : S_IDLE;
            end
         end
         S_FAIL: begin
            if (do_sreset) begin
               next_state = S_RECOVER;
            end else if (do_clear_status_cmd) begin
               next_state = S_IDLE;
            end
         end
         S_RECOVER: begin
            if (timer == 12'h000) begin
               next_state = S_IDLE;
            end
         end
      endcase
   end

   // state, busy flag and operation timer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= S_INIT;
         write_in_progress <= 1'b1;
         timer <= '0;
         kind <= K_ERASE;
         pending <= '0;
      end else begin
         state <= next_state;
         write_in_progress <= (next_state != S_IDLE);
         if (do_sreset) begin
            timer <= RECOVERY_CYCLES - 12'h001;
         end else if (idle & next_state == S_BUSY) begin
            timer <= OP_CYCLES - 12'h001;
         end else if (timer != 12'h000) begin
            timer <= timer - 12'h001;
         end
         if (start_erase) kind <= K_ERASE;
         if (start_clear) kind <= K_CLEAR;
         if (start_prog) kind <= K_PROG;
         if (start_unlock) kind <= K_UNLOCK;
         if (cmd72 & idle) begin
            pending <= byte_swap64(shift[63:0]);
         end
      end
   end

   // write enable latch
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         write_enable_latch <= 1'b0;
      end else if (do_sreset) begin
         write_enable_latch <= 1'b0;
      end else if (do_write_enable_cmd) begin
         write_enable_latch <= 1'b1;
      end else if (busy_done & kind != K_UNLOCK) begin
         write_enable_latch <= 1'b0;
      end
   end

   // program error flag
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         program_error <= 1'b0;
      end else if (busy_done & op_fails) begin
         program_error <= 1'b1;
      end else if (do_clear_status_cmd | do_sreset) begin
         program_error <= 1'b0;
      end
   end

   // lock bit: power-on value from the mode, kept over soft reset;
   // the mode pin is read directly, its register still holds reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         protect_lock <= 1'b0;
      end else if (state == S_INIT) begin
         protect_lock <= pw_mode_sel_n;
      end else if (busy_done & kind == K_CLEAR) begin
         protect_lock <= 1'b0;
      end else if (busy_done & kind == K_UNLOCK & ~mismatch) begin
         protect_lock <= 1'b1;
      end
   end

   // protection array and stored password
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         persistent_protect_bits <= PPB_ERASED;
         password <= PW_ERASED;
      end else begin
         if (busy_done & kind == K_ERASE) begin
            persistent_protect_bits <= PPB_ERASED;
         end
         if (busy_done & kind == K_PROG & ~prog_bad) begin
            password <= pending;
         end
      end
   end

   logic cfg_block_protect_volatility_q;

   // configuration: freeze only cleared by the hardware reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         config_freeze <= 1'b0;
         block_protect <= BP_RESET;
      end else if (do_sreset) begin
         if (cfg_block_protect_volatility_q & ~config_freeze) begin
            block_protect <= BP_RESET;
         end
      end else if (cfg_load & ~config_freeze) begin
         config_freeze <= cfg_freeze;
         block_protect <= cfg_bp;
      end
   end

   // non-volatile volatility select survives soft reset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_block_protect_volatility_q <= 1'b0;
      end else if (cfg_load & ~config_freeze) begin
         cfg_block_protect_volatility_q <= cfg_block_protect_volatility;
      end
   end

   // continuous read mode flag; entry wins over release
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cont_read_mode <= 1'b0;
      end else if (cont_mode_enter) begin
         cont_read_mode <= 1'b1;
      end else if (do_mbr | do_sreset) begin
         cont_read_mode <= 1'b0;
      end
   end

   // registered sources for the link-side mirror
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pw_mode_q <= 1'b1;
         st_q <= '0;
      end else begin
         pw_mode_q <= pw_mode_sel_n;
         st_q <= {1'b0, program_error, 1'b0, block_protect,
                  write_enable_latch, write_in_progress};
      end
   end
   assign mir_src = {pw_mode_q, protect_lock, st_q, password};

endmodule
`default_nettype wire

// >>> hw/spc_host.sv
// host end: frames commands onto the serial link
`timescale 1ns/10ps
`default_nettype none
module spc_host
   import spc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   spc_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_op,
   input wire logic [63:0] cmd_data,
   input wire logic cmd_tx_data,
   input wire logic [6:0] cmd_rx_bits,
   output logic rsp_valid,
   output logic rsp_refused,
   output logic [63:0] rsp_data
);

   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END, H_GAP} spc_host_state_e;

   // ---------------------------------------------------------------
   // serial input synchroniser
   // ---------------------------------------------------------------
   logic [2:0] so_s;
   logic so_lvl;

   // read data passes three flops; a change counts when two agree
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         so_s <= '0;
         so_lvl <= 1'b0;
      end else begin
         so_s <= {so_s[1:0], link.so};
         if (so_s[1] == so_s[2]) begin
            so_lvl <= so_s[2];
         end
      end
   end

   // ---------------------------------------------------------------
   // frame sequencer
   // ---------------------------------------------------------------
   spc_host_state_e state;
   logic boot;
   logic [2:0] phase;
   logic [7:0] bits_left;
   logic [71:0] tx;
   logic [63:0] rx;
   logic [6:0] rx_bits;
   logic [7:0] cur_op;
   logic [4:0] gap;
   logic last_wip;
   logic take;

   assign take = (state == H_IDLE) & cmd_ready & cmd_valid;

   // clock divides ref_clk by 8, far below the 133 MHz ceiling
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= H_IDLE;
         boot <= 1'b1;
         cmd_ready <= 1'b0;
         link.sck <= 1'b0;
         link.cs_n <= 1'b1;
         link.si <= 1'b0;
         phase <= '0;
         bits_left <= '0;
         tx <= '0;
         rx <= '0;
         rx_bits <= '0;
         cur_op <= '0;
         gap <= '0;
      end else begin
         unique case (state)
            H_IDLE: begin
               if (boot) begin
                  boot <= 1'b0;
                  tx <= {OP_MODE_RELEASE, 64'h0};
                  cur_op <= OP_MODE_RELEASE;
                  bits_left <= 8'h08;
                  rx_bits <= '0;
                  link.cs_n <= 1'b0;
                  phase <= '0;
                  state <= H_SHIFT;
               end else if (take & ~(cmd_op == OP_LOCK_READ & last_wip)) begin
                  cmd_ready <= 1'b0;
                  cur_op <= cmd_op;
                  tx <= {cmd_op, cmd_tx_data ? byte_swap64(cmd_data) : 64'h0};
                  bits_left <= 8'h08 + (cmd_tx_data ? 8'h40 : 8'h00)
                     + {1'b0, cmd_rx_bits};
                  rx_bits <= cmd_rx_bits;
                  link.cs_n <= 1'b0;
                  phase <= '0;
                  state <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               phase <= phase + 3'h1;
               if (phase == 3'h0) begin
                  link.sck <= 1'b0;
                  link.si <= tx[71];
                  tx <= {tx[70:0], 1'b0};
               end
               if (phase == SCK_HALF) begin
                  link.sck <= 1'b1;
               end
               if (phase == 3'h7) begin
                  rx <= {rx[62:0], so_lvl};
                  bits_left <= bits_left - 8'h01;
                  if (bits_left == 8'h01) begin
                     state <= H_END;
                  end
               end
            end
            H_END: begin
               link.sck <= 1'b0;
               link.cs_n <= 1'b1;
               gap <= CS_GAP_CYCLES;
               state <= H_GAP;
            end
            H_GAP: begin
               gap <= gap - 5'h01;
               if (gap == 5'h01) begin
                  cmd_ready <= 1'b1;
                  state <= H_IDLE;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // answers and busy tracking
   // ---------------------------------------------------------------
   // lock read is refused while the last status read showed busy
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rsp_valid <= 1'b0;
         rsp_refused <= 1'b0;
         rsp_data <= '0;
         last_wip <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (take & cmd_op == OP_LOCK_READ & last_wip) begin
            rsp_valid <= 1'b1;
            rsp_refused <= 1'b1;
            rsp_data <= '0;
         end else if (state == H_END & cur_op != OP_MODE_RELEASE) begin
            rsp_valid <= 1'b1;
            rsp_refused <= 1'b0;
            rsp_data <= (rx_bits == PW_RX_BITS) ? byte_swap64(rx)
               : {56'h0, rx[7:0]};
            if (cur_op == OP_READ_STATUS & rx_bits != 7'h00) begin
               last_wip <= rx[SR_WIP];
            end
         end
      end
   end

endmodule
`default_nettype wire

// >>> verification/spc_chk.sv
// assertions on the link and the status flags of the flash end
`timescale 1ns/10ps
`default_nettype none
module spc_chk (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic so,
   input wire logic write_enable_latch,
   input wire logic write_in_progress,
   input wire logic program_error,
   input wire logic protect_lock
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // link clock rests low between frames and keeps its half period
   sck_idle_a: assert property (cs_n |-> !sck)
      else $error("clock moves while deselected");
   cs_gap_a: assert property ($rose(cs_n) |=> cs_n [*8] ##1 cs_n [*7])
      else $error("select gap short");
   sck_half_a: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
      else $error("clock half period wrong");
   so_hold_a: assert property (sck && $past(sck) |-> $stable(so))
      else $error("data out moved with clock high");
   si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
      else $error("data in moved with clock high");
   // flags rise only with select high or next to busy, each for its own cause
   wel_set_a: assert property (
      $rose(write_enable_latch) |-> cs_n && !$past(write_in_progress))
      else $error("write enable set at wrong time");
   busy_start_a: assert property ($rose(write_in_progress) |-> cs_n)
      else $error("busy rose inside a frame");
   err_busy_a: assert property (
      $rose(program_error) |=> write_in_progress [*8])
      else $error("error without busy");
   lock_set_a: assert property (
      $rose(protect_lock) |-> $past(write_in_progress)
      || $past(write_in_progress, 2))
      else $error("lock set outside an operation");
   cover property ($rose(protect_lock));
   cover property ($rose(program_error));
   cover property ($fell(write_enable_latch));
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// bench: host and flash ends on one link, checked against a model
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import spc_pkg::*;
;
   logic ref_clk = 0, rstn = 0, cmd_valid = 0, cmd_tx_data = 0;
   logic pw_mode_sel_n = 1, cfg_load = 0, cfg_freeze = 0, cfg_block_protect_volatility = 0;
   logic cont_mode_enter = 0, cmd_ready, rsp_valid, rsp_refused;
   logic wr_en, busy, err, lock, frz, cont;
   logic [2:0] cfg_bp = '0, bp;
   logic [6:0] cmd_rx_bits = '0;
   logic [7:0] cmd_op = '0, prot;
   logic [63:0] cmd_data = '0, rsp_data, rd, pw;
   logic si_q[$], so_q[$];
   int miscompares = 0, checked = 0, seed = 67628, cyc = 0, n, c, m_lock;
   spc_if link ();
   spc_flash i_spc_flash (.ref_clk, .rstn, .link(link.dev), .pw_mode_sel_n,
      .cfg_load, .cfg_freeze, .cfg_block_protect_volatility, .cfg_bp, .cont_mode_enter,
      .write_enable_latch(wr_en), .write_in_progress(busy),
      .program_error(err), .protect_lock(lock),
      .persistent_protect_bits(prot), .block_protect(bp),
      .config_freeze(frz), .cont_read_mode(cont));
   spc_host i_spc_host (.ref_clk, .rstn, .link(link.host), .cmd_valid,
      .cmd_ready, .cmd_op, .cmd_data, .cmd_tx_data, .cmd_rx_bits, .rsp_valid,
      .rsp_refused, .rsp_data);
   spc_chk i_spc_chk (.ref_clk, .rstn, .sck(link.sck), .cs_n(link.cs_n),
      .si(link.si), .so(link.so), .write_enable_latch(wr_en),
      .write_in_progress(busy), .program_error(err), .protect_lock(lock));
   // 50 MHz core clock
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   // hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         miscompares++;
         close_out();
      end
   end
   // wire capture of both data lines inside frames
   always @(posedge link.sck) begin
      if (!link.cs_n) begin
         si_q.push_back(link.si);
         so_q.push_back(link.so);
      end
   end
   task automatic close_out;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   // one host command, then time for the device sync to settle
   task automatic cmd(input logic [7:0] op, input logic [63:0] d,
      input logic tx, input logic [6:0] rx);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 3000) begin
         tick();
         n++;
      end
      si_q.delete();
      so_q.delete();
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      cmd_tx_data <= tx;
      cmd_rx_bits <= rx;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 1500) begin
         tick();
         n++;
      end
      rd = rsp_data;
      repeat (8) tick();
   endtask
   task automatic idle;
      c = 0;
      while (busy === 1'b1 && c < 4000) begin
         tick();
         c++;
      end
   endtask
   task automatic cfg(input logic f);
      @(posedge ref_clk);
      cfg_freeze <= f;
      cfg_block_protect_volatility <= 1'b1;
      cfg_bp <= 3'h5;
      cfg_load <= 1'b1;
      cont_mode_enter <= 1'b1;
      @(posedge ref_clk);
      cfg_load <= 1'b0;
      cont_mode_enter <= 1'b0;
      tick();
   endtask
   // scenarios
   initial begin
      pw = {$random(seed), $random(seed)};
      m_lock = 1;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      cmd(OP_LOCK_READ, '0, 1'b0, 7'h10);
      chk(rd[7:0], 8'(m_lock));
      for (int i = 0; i < 16; i++) begin
         chk(so_q[8 + i], (i % 8 == 7) && m_lock);
      end
      cmd(OP_LOCK_CLEAR, '0, 1'b0, '0);
      idle();
      chk({c, lock}, 33'h1);
      cmd(OP_WRITE_ENABLE, '0, 1'b0, '0);
      chk(wr_en, 1'b1);
      cmd(OP_PROTECT_ERASE, '0, 1'b0, 7'h08);
      idle();
      chk({c, wr_en}, 33'h1);
      cmd(OP_PROTECT_ERASE, '0, 1'b0, '0);
      cmd(OP_ERASE_SUSPEND, '0, 1'b0, '0);
      idle();
      chk(c > 2000, 1'b1);
      chk({wr_en, prot}, {1'b0, PPB_ERASED});
      cmd(OP_WRITE_ENABLE, '0, 1'b0, '0);
      cmd(OP_LOCK_CLEAR, '0, 1'b0, '0);
      chk(busy, 1'b1);
      idle();
      m_lock = 0;
      chk({wr_en, lock}, 2'(m_lock));
      cmd(OP_WRITE_ENABLE, '0, 1'b0, '0);
      cmd(OP_PW_PROGRAM, pw, 1'b1, '0);
      chk(si_q.size(), 72);
      for (int s = 0; s < 64; s++) begin
         chk(si_q[8 + s], pw[8 * (s / 8) + 7 - s % 8]);
      end
      idle();
      chk(wr_en, 1'b0);
      cmd(OP_PW_READ, '0, 1'b0, 7'h40);
      chk(rd, pw);
      cmd(OP_PW_UNLOCK, ~pw, 1'b1, '0);
      idle();
      chk({c, err, busy}, {32'd4000, 2'b11});
      cmd(OP_READ_STATUS, '0, 1'b0, 7'h08);
      chk(rd[7:0] & 8'h41, 8'h41);
      cmd(OP_LOCK_READ, '0, 1'b0, 7'h08);
      chk(rsp_refused, 1'b1);
      cmd(OP_CLEAR_STATUS, '0, 1'b0, '0);
      idle();
      chk({err, busy}, 2'b00);
      cmd(OP_PW_UNLOCK, pw, 1'b1, '0);
      chk(busy, 1'b1);
      idle();
      m_lock = 1;
      chk({err, lock}, 2'(m_lock));
      for (int k = 0; k < 2; k++) begin
         cfg(k[0]);
         chk({cont, bp}, 4'hd);
         cmd(OP_MODE_RELEASE, '0, 1'b0, '0);
         chk(cont, 1'b0);
         cmd(OP_WRITE_ENABLE, '0, 1'b0, '0);
         cmd(OP_SOFT_RESET, '0, 1'b0, '0);
         idle();
         chk(c > RECOVERY_CYCLES - 40 && c < OP_CYCLES, 1'b1);
         chk({wr_en, lock, frz, bp},
            {2'(m_lock), k[0], k[0] ? 3'h5 : 3'h0});
      end
      @(posedge ref_clk);
      pw_mode_sel_n <= 1'b0;
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      cmd(OP_WRITE_ENABLE, '0, 1'b0, '0);
      chk({lock, frz}, 2'b00);
      cmd(OP_PW_READ, '0, 1'b0, 7'h40);
      chk(rd, 64'h0);
      chk(rsp_refused, 1'b0);
      cmd(OP_PW_PROGRAM, ~pw, 1'b1, '0);
      idle();
      chk({c, wr_en}, 33'h1);
      close_out();
   end
endmodule
`default_nettype wire
